/* ime_event_select.sv */
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - code 0x10 counts cycles ingress not empty, umask classes, bit 7 all
// - code 0x11 adds ingress entries written, same classes, counters 0-3
// - code 0x25 counts egress full cycles, bit 3 port one, bit 7 port zero
// - code 0x23 counts egress not empty cycles, counters 0-1 only
// - every counter selects its own event and umask independently
// - code 0x2D credit event on counters 0-1, bit 0 prefetch, bit 1 persistent
// - code 0x15 shared credit received, bits 0-3 classes, bit 4 all
// - dedicated credit received uses same five qualifiers as shared
// - dedicated credit taken codes 0x48 links 0-1, 0x49 link 2
// - code 0x1B dedicated returned, bypass then standard per link, bits 0-5
// - shared returned by agent bits 0-2, 0x18 ingress, 0x45 egress
// - shared credit taken codes 0x42 links 0-1, 0x43 link 2
// - shared credit wait codes 0x4C links 0-1, 0x4D link 2
// - egress inserts 0x50 address, 0x51 ack, 0x52 block ring
module ime_event_select
  import ime_pkg::*;
#(
  parameter int N_CTR = NUM_CTR
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata,
  input  wire ime_events_s       events,
  output logic [N_CTR-1:0]       ctr_wrapped
);

  if (N_CTR < 2 || N_CTR > 4) begin : g_chk
    $error("ime_event_select: counter count must be 2 to 4");
  end

  if (RESTRICT_MAX_IDX >= N_CTR) begin : g_chk_restrict
    $error("ime_event_select: restricted events need a counter to live on");
  end

  // seven sources must fit an increment, and an increment must fit the threshold
  if (INC_W < 3 || INC_W > 8) begin : g_chk_inc
    $error("ime_event_select: increment width must be 3 to 8");
  end

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [INC_W-1:0] ones7(input logic [6:0] v);
    logic [INC_W-1:0] n;
    n = '0;
    for (int i = 0; i < 7; i++) begin
      n = n + {{(INC_W-1){1'b0}}, v[i]};
    end
    return n;
  endfunction

  function automatic logic [INC_W-1:0] hit(input logic any);
    return {{(INC_W-1){1'b0}}, any};
  endfunction

  // byte address of one slot in a strided register bank
  function automatic logic [ADDR_W-1:0] slot_addr(input logic [ADDR_W-1:0] base,
                                                  input logic [ADDR_W-1:0] stride,
                                                  input int                idx);
    return base + ADDR_W'(idx) * stride;
  endfunction

  // raw per-cycle amount for one counter's selection
  function automatic logic [INC_W-1:0] decode(input ime_ctl_s c, input ime_events_s e);
    logic [7:0]       m;
    logic [INC_W-1:0] r;
    m = c.umask;
    r = '0;
    // codes outside the table add nothing
    case (c.code)
      EV_ING_NE: begin
        r = hit(m[7] ? |e.ingress_not_empty : |(m[6:0] & e.ingress_not_empty));
      end
      EV_ING_WR: begin
        r = ones7(m[7] ? e.ingress_entry_writes
                       : m[6:0] & e.ingress_entry_writes);
      end
      EV_EGR_FULL: begin
        r = hit((m[3] & e.egress_full[1]) | (m[7] & e.egress_full[0]));
      end
      EV_EGR_NE: begin
        r = hit((m[3] & e.egress_not_empty[1]) | (m[7] & e.egress_not_empty[0]));
      end
      EV_EGR_CRD: begin
        r = hit(|(m[1:0] & e.egress_credit));
      end
      EV_SHR_RCV: begin
        r = hit(m[4] ? |e.shared_received : |(m[3:0] & e.shared_received));
      end
      EV_DED_RCV: begin
        r = hit(m[4] ? |e.dedicated_received : |(m[3:0] & e.dedicated_received));
      end
      EV_RDED_TAKEN_LO: begin
        r = hit(|(m[5:0] & e.remote_dedicated_taken[5:0]));
      end
      EV_RDED_TAKEN_HI: begin
        r = hit(|(m[2:0] & e.remote_dedicated_taken[8:6]));
      end
      EV_RDED_RET: begin
        r = hit(|(m[5:0] & e.remote_dedicated_returned));
      end
      EV_RSHR_RET_IN: begin
        r = hit(|(m[2:0] & e.remote_shared_returned_in));
      end
      EV_RSHR_RET_OUT: begin
        r = hit(|(m[2:0] & e.remote_shared_returned_out));
      end
      EV_RSHR_TAKEN_LO: begin
        r = hit(|(m[5:0] & e.remote_shared_taken[5:0]));
      end
      EV_RSHR_TAKEN_HI: begin
        r = hit(|(m[2:0] & e.remote_shared_taken[8:6]));
      end
      EV_RSHR_WAIT_LO: begin
        r = hit(|(m[5:0] & e.remote_shared_wait[5:0]));
      end
      EV_RSHR_WAIT_HI: begin
        r = hit(|(m[2:0] & e.remote_shared_wait[8:6]));
      end
      EV_INS_ADDR: begin
        r = hit(|(m[5:0] & e.inserts_address_ring));
      end
      EV_INS_ACK: begin
        r = hit(|(m[5:0] & e.inserts_ack_ring));
      end
      EV_INS_BLOCK: begin
        r = hit(|(m[4:0] & e.inserts_block_ring));
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // events that exist only on the low counters
  function automatic logic restricted(input logic [7:0] code);
    return (code == EV_EGR_NE) || (code == EV_EGR_CRD);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // event source stage

  ime_events_s ev_q;

  ime_event_stage u_stage (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ev_in   (events),
    .ev_ff   (ev_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  logic [N_CTR-1:0] ctl_hit;
  logic [N_CTR-1:0] lo_hit;
  logic [N_CTR-1:0] hi_hit;
  logic             stat_hit;

  // every slot is compared, so an unmapped address simply misses them all
  always_comb begin
    for (int i = 0; i < N_CTR; i++) begin
      ctl_hit[i] = reg_addr == slot_addr(CTL_BASE, CTL_STRIDE, i);
      lo_hit[i]  = reg_addr == slot_addr(CTR_LO_BASE, CTR_STRIDE, i);
      hi_hit[i]  = reg_addr == slot_addr(CTR_HI_BASE, CTR_STRIDE, i);
    end
    stat_hit = reg_addr == STATUS_OFS;
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers; the clear bit acts once and is not kept

  ime_ctl_s [N_CTR-1:0] ctl_ff;
  logic     [N_CTR-1:0] clr_req;

  // reserved bits are kept and read back as written
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctl_ff <= {N_CTR{CTL_RESET}};
    end else begin
      for (int i = 0; i < N_CTR; i++) begin
        if (reg_wr && ctl_hit[i]) begin
          ctl_ff[i]     <= reg_wdata;
          ctl_ff[i].clr <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N_CTR; i++) begin
      clr_req[i] = reg_wr & ctl_hit[i] & reg_wdata[CLR_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-counter qualification: threshold, invert, edge

  logic [N_CTR-1:0][INC_W-1:0] raw_inc;
  logic [N_CTR-1:0][INC_W-1:0] ctr_inc;
  logic [N_CTR-1:0]            cond;
  logic [N_CTR-1:0]            cond_ff;
  logic [N_CTR-1:0]            en_ff;
  logic [N_CTR-1:0]            bad;

  // restricted codes on high counters count nothing; software reads the flag in status
  always_comb begin
    for (int i = 0; i < N_CTR; i++) begin
      // outside the permitted range the count is undefined; we simply hold
      bad[i] = restricted(ctl_ff[i].code) && (i > RESTRICT_MAX_IDX);
    end
  end

  // each counter decodes its own control word, so any mix of permitted codes runs side by side
  always_comb begin
    for (int i = 0; i < N_CTR; i++) begin
      raw_inc[i] = decode(ctl_ff[i], ev_q);
      if (ctl_ff[i].thr == 8'h00) begin
        cond[i] = ctl_ff[i].inv ? (raw_inc[i] == '0) : (raw_inc[i] != '0);
      end else begin
        cond[i] = ctl_ff[i].inv ? (8'(raw_inc[i]) < ctl_ff[i].thr)
                                : (8'(raw_inc[i]) >= ctl_ff[i].thr);
      end
      if (!ctl_ff[i].en || bad[i]) begin
        ctr_inc[i] = '0;
      end else if (ctl_ff[i].edge_det) begin
        // no edge in the first enabled cycle: the history is not yet valid
        ctr_inc[i] = hit(cond[i] & ~cond_ff[i] & en_ff[i]);
      end else if (ctl_ff[i].thr == 8'h00 && !ctl_ff[i].inv) begin
        ctr_inc[i] = raw_inc[i];
      end else begin
        ctr_inc[i] = hit(cond[i]);
      end
    end
  end

  // history is cleared to zero while disabled, and en_ff masks the first enabled cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cond_ff <= '0;
      en_ff   <= '0;
    end else begin
      for (int i = 0; i < N_CTR; i++) begin
        cond_ff[i] <= ctl_ff[i].en & cond[i];
        en_ff[i]   <= ctl_ff[i].en;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counters

  logic [N_CTR-1:0][CTR_W-1:0] cnt;
  logic [N_CTR-1:0]            wrap;

  // a load or clear drops the count of its own cycle
  for (genvar g = 0; g < N_CTR; g++) begin : g_ctr
    ime_counter #(
      .W (CTR_W)
    ) u_ctr (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clr     (clr_req[g]),
      .load_lo (reg_wr & lo_hit[g]),
      .load_hi (reg_wr & hi_hit[g]),
      .wdata   (reg_wdata),
      .inc     (ctr_inc[g]),
      .cnt_ff  (cnt[g]),
      .wrap    (wrap[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky wrap flags: write one to clear, a new wrap wins over the clear

  logic [N_CTR-1:0] wrap_ff;
  logic [N_CTR-1:0] wrap_clr;

  // the wrap of the clear cycle is kept, so no overflow goes unseen
  assign wrap_clr = (reg_wr && stat_hit) ? reg_wdata[STAT_WRAP_LSB +: N_CTR] : '0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrap_ff <= '0;
    end else begin
      wrap_ff <= (wrap_ff & ~wrap_clr) | wrap;
    end
  end

  assign ctr_wrapped = wrap_ff;

  //////////////////////////////////////////////////////////////////////////////
  // read path: data one cycle after the strobe, zero for unmapped addresses

  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] rdata_ff;

  always_comb begin
    nxt_rdata = DATA_ZERO;
    for (int i = 0; i < N_CTR; i++) begin
      if (ctl_hit[i]) begin
        nxt_rdata = ctl_ff[i];
      end
      if (lo_hit[i]) begin
        nxt_rdata = cnt[i][DATA_W-1:0];
      end
      if (hi_hit[i]) begin
        nxt_rdata = {{(2 * DATA_W - CTR_W){1'b0}}, cnt[i][CTR_W-1:DATA_W]};
      end
    end
    if (stat_hit) begin
      nxt_rdata[STAT_WRAP_LSB +: N_CTR] = wrap_ff;
      nxt_rdata[STAT_BAD_LSB +: N_CTR]  = bad;
    end
  end

  // the halves are read apart; a carry between the two reads tears the value
  // data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= DATA_ZERO;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= DATA_ZERO;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

/* ime_pkg.sv */
package ime_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_CTR      = 4;
  localparam int CTR_W        = 48;
  localparam int DATA_W       = 32;
  localparam int ADDR_W       = 8;
  localparam int INC_W        = 4;
  // event only legal on counters 0..RESTRICT_MAX_IDX when restricted
  localparam int RESTRICT_MAX_IDX = 1;

  //////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] CTL_BASE    = 8'h00;
  localparam logic [ADDR_W-1:0] CTL_STRIDE  = 8'h04;
  localparam logic [ADDR_W-1:0] CTR_LO_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] CTR_HI_BASE = 8'h14;
  localparam logic [ADDR_W-1:0] CTR_STRIDE  = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 8'h30;

  // field positions in a control word
  localparam int CODE_LSB   = 0;
  localparam int UMASK_LSB  = 8;
  localparam int CLR_BIT    = 17;
  localparam int EDGE_BIT   = 18;
  localparam int EN_BIT     = 22;
  localparam int INV_BIT    = 23;
  localparam int THR_LSB    = 24;
  // status word: sticky wrap flags low, restriction violations above
  localparam int STAT_WRAP_LSB = 0;
  localparam int STAT_BAD_LSB  = 4;

  localparam logic [DATA_W-1:0] CTL_RESET  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [7:0] {
    EV_NONE          = 8'h00,
    EV_ING_NE        = 8'h10,
    EV_ING_WR        = 8'h11,
    EV_SHR_RCV       = 8'h15,
    EV_DED_RCV       = 8'h16,
    EV_RSHR_RET_IN   = 8'h18,
    EV_RDED_RET      = 8'h1B,
    EV_EGR_NE        = 8'h23,
    EV_EGR_FULL      = 8'h25,
    EV_EGR_CRD       = 8'h2D,
    EV_RSHR_TAKEN_LO = 8'h42,
    EV_RSHR_TAKEN_HI = 8'h43,
    EV_RSHR_RET_OUT  = 8'h45,
    EV_RDED_TAKEN_LO = 8'h48,
    EV_RDED_TAKEN_HI = 8'h49,
    EV_RSHR_WAIT_LO  = 8'h4C,
    EV_RSHR_WAIT_HI  = 8'h4D,
    EV_INS_ADDR      = 8'h50,
    EV_INS_ACK       = 8'h51,
    EV_INS_BLOCK     = 8'h52
  } ime_code_e;

  typedef struct packed {
    logic [7:0] thr;
    logic       inv;
    logic       en;
    logic [2:0] rsv_hi;
    logic       edge_det;
    logic       clr;
    logic       rsv_lo;
    logic [7:0] umask;
    logic [7:0] code;
  } ime_ctl_s;

  // per-link class triples are {standard, bypass, data_response}, link 0 lowest
  typedef struct packed {
    logic [6:0] ingress_not_empty;
    logic [6:0] ingress_entry_writes;
    logic [1:0] egress_full;
    logic [1:0] egress_not_empty;
    logic [1:0] egress_credit;
    logic [3:0] shared_received;
    logic [3:0] dedicated_received;
    logic [8:0] remote_dedicated_taken;
    logic [5:0] remote_dedicated_returned;
    logic [2:0] remote_shared_returned_in;
    logic [2:0] remote_shared_returned_out;
    logic [8:0] remote_shared_taken;
    logic [8:0] remote_shared_wait;
    logic [5:0] inserts_address_ring;
    logic [5:0] inserts_ack_ring;
    logic [4:0] inserts_block_ring;
  } ime_events_s;

endpackage

/* ime_event_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module ime_event_stage
  import ime_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire ime_events_s ev_in,
  output ime_events_s      ev_ff
);

  // one flop stage so the wide decode never sits on the queue-side paths
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ev_ff <= '0;
    end else begin
      ev_ff <= ev_in;
    end
  end

endmodule
`default_nettype wire

/* ime_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module ime_counter
  import ime_pkg::*;
#(
  parameter int W = CTR_W
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clr,
  input  wire logic              load_lo,
  input  wire logic              load_hi,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [INC_W-1:0]  inc,
  output logic [W-1:0]           cnt_ff,
  output logic                   wrap
);

  if (W <= DATA_W || W > 2 * DATA_W) begin : g_chk
    $error("ime_counter: width must span two data words");
  end

  logic [W:0] sum;

  assign sum  = {1'b0, cnt_ff} + {{(W + 1 - INC_W){1'b0}}, inc};
  assign wrap = sum[W] & ~clr & ~load_lo & ~load_hi;

  // software load wins over counting in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst || clr) begin
      cnt_ff <= '0;
    end else if (load_lo) begin
      cnt_ff <= {cnt_ff[W-1:DATA_W], wdata};
    end else if (load_hi) begin
      cnt_ff <= {wdata[W-DATA_W-1:0], cnt_ff[DATA_W-1:0]};
    end else begin
      cnt_ff <= sum[W-1:0];
    end
  end

endmodule
`default_nettype wire

/* ime_event_select_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ime_es_assertions
  import ime_pkg::*;
#(
  parameter int N_CTR = NUM_CTR
)
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire ime_events_s       events,
  input wire logic [N_CTR-1:0]  ctr_wrapped
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // flags that software clears in this cycle
  logic [N_CTR-1:0] clr_m;
  assign clr_m = (reg_wr && reg_addr == STATUS_OFS) ? reg_wdata[N_CTR-1:0] : '0;

  //////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == DATA_ZERO)
    else $error("read data not zero outside a read answer");
  unmapped_zero_a: assert property (reg_rd && reg_addr >= 8'h40 |=> reg_rdata == DATA_ZERO)
    else $error("unmapped read returned nonzero data");
  hi_upper_zero_a: assert property (reg_rd && reg_addr >= CTR_HI_BASE
      && reg_addr < STATUS_OFS && reg_addr[2:0] == 3'h4 |=> reg_rdata[31:16] == 16'h0000)
    else $error("counter high word upper half not zero");
  // status mirrors the wrap flags held before the read edge
  status_word_a: assert property (reg_rd && reg_addr == STATUS_OFS |=>
      reg_rdata[31:8] == 24'h000000 && reg_rdata[N_CTR-1:0] == $past(ctr_wrapped))
    else $error("status word does not match wrap flags");
  ctl_readback_a: assert property (
      reg_wr && reg_addr < CTR_LO_BASE && reg_addr[1:0] == 2'h0 ##1
      reg_rd && reg_addr == $past(reg_addr) |=>
      (reg_rdata & 32'hFFC6_FFFF) == ($past(reg_wdata, 2) & 32'hFFC4_FFFF))
    else $error("control word read back differs from write");
  // a flag only falls when software wrote a one to it
  wrap_sticky_a: assert property (|ctr_wrapped |=>
      ($past(ctr_wrapped) & ~$past(clr_m) & ~ctr_wrapped) == '0)
    else $error("wrap flag dropped without a clear");
  wrap_reset_a: assert property ($fell(rst) |-> ctr_wrapped == '0)
    else $error("wrap flags not cleared by reset");
  rdata_reset_a: assert property ($fell(rst) |-> reg_rdata == DATA_ZERO)
    else $error("read data not zero after reset");
endmodule

bind ime_event_select ime_es_assertions #(.N_CTR(N_CTR)) chk_u (
  .ref_clk    (ref_clk),
  .rst        (rst),
  .reg_addr   (reg_addr),
  .reg_wdata  (reg_wdata),
  .reg_wr     (reg_wr),
  .reg_rd     (reg_rd),
  .reg_rdata  (reg_rdata),
  .events     (events),
  .ctr_wrapped(ctr_wrapped)
);
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import ime_pkg::*;
;
  localparam logic [7:0] CODES [19] = '{8'h10, 8'h11, 8'h15, 8'h16, 8'h18, 8'h1B, 8'h23,
    8'h25, 8'h2D, 8'h42, 8'h43, 8'h45, 8'h48, 8'h49, 8'h4C, 8'h4D, 8'h50, 8'h51, 8'h52};
  // well above the roughly thirteen hundred cycles the sequence needs
  localparam int LIMIT = 6000;

  logic              ref_clk = 1'b0;
  logic              rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  ime_events_s       ev;
  logic [3:0]        ctr_wrapped;
  logic [7:0]        c [4];
  logic [7:0]        m [4];
  logic [47:0]       exp_c [4];
  logic [3:0]        bad;
  logic [31:0]       seed;
  logic [31:0]       q;
  ime_events_s       v1;
  int                cycles = 0;
  int                mismatches;
  int                n_compared;

  ime_event_select #(.N_CTR(4)) dut_u (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .events     (ev),
    .ctr_wrapped(ctr_wrapped)
  );

  always #2.5 ref_clk = ~ref_clk;

  //////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0);
    return seed;
  endfunction

  // amount one counter adds for one cycle of event levels
  function automatic logic [3:0] inc(input logic [7:0] cd, input logic [7:0] mk,
                                     input ime_events_s e);
    logic [6:0] s;
    logic       b;
    s = mk[7] ? e.ingress_entry_writes : (e.ingress_entry_writes & mk[6:0]);
    case (cd)
      8'h10: b = mk[7] ? |e.ingress_not_empty : |(e.ingress_not_empty & mk[6:0]);
      8'h11: return 4'($countones(s));
      8'h25: b = (mk[7] & e.egress_full[0]) | (mk[3] & e.egress_full[1]);
      8'h23: b = (mk[7] & e.egress_not_empty[0]) | (mk[3] & e.egress_not_empty[1]);
      8'h2D: b = |(e.egress_credit & mk[1:0]);
      8'h15: b = mk[4] ? |e.shared_received : |(e.shared_received & mk[3:0]);
      8'h16: b = mk[4] ? |e.dedicated_received : |(e.dedicated_received & mk[3:0]);
      8'h48: b = |(e.remote_dedicated_taken[5:0] & mk[5:0]);
      8'h49: b = |(e.remote_dedicated_taken[8:6] & mk[2:0]);
      8'h1B: b = |(e.remote_dedicated_returned & mk[5:0]);
      8'h18: b = |(e.remote_shared_returned_in & mk[2:0]);
      8'h45: b = |(e.remote_shared_returned_out & mk[2:0]);
      8'h42: b = |(e.remote_shared_taken[5:0] & mk[5:0]);
      8'h43: b = |(e.remote_shared_taken[8:6] & mk[2:0]);
      8'h4C: b = |(e.remote_shared_wait[5:0] & mk[5:0]);
      8'h4D: b = |(e.remote_shared_wait[8:6] & mk[2:0]);
      8'h50: b = |(e.inserts_address_ring & mk[5:0]);
      8'h51: b = |(e.inserts_ack_ring & mk[5:0]);
      8'h52: b = |(e.inserts_block_ring & mk[4:0]);
      default: b = 1'b0;
    endcase
    return {3'h0, b};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
    n_compared++;
    if (got !== exp_v) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp_v);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask

  // write, then read back in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    r = reg_rdata;
  endtask

  // all four counters run their own selection on one random event stream
  task automatic run_round();
    logic [31:0] d;
    logic [95:0] r96;
    ime_events_s v;
    for (int i = 0; i < 4; i++) begin
      d = 32'h0042_0000 | {16'h0, m[i], c[i]};
      wr_rd(8'(4 * i), d, q);
      chk(q, d & 32'hFFC4_FFFF);
      exp_c[i] = '0;
      bad[i] = (i > 1) && (c[i] == 8'h23 || c[i] == 8'h2D);
    end
    for (int k = 0; k < 32; k++) begin
      r96 = {rnd(), rnd(), rnd()};
      v = ime_events_s'(r96[83:0]);
      @(posedge ref_clk);
      ev <= v;
      for (int i = 0; i < 4; i++) begin
        if (!bad[i]) exp_c[i] += 48'(inc(c[i], m[i], v));
      end
    end
    @(posedge ref_clk);
    ev <= '0;
    repeat (3) @(posedge ref_clk);
    rd(STATUS_OFS, q);
    chk(q, {24'h0, bad, 4'h0});
    for (int i = 0; i < 4; i++) begin
      rd(CTR_LO_BASE + 8'(8 * i), q);
      chk(q, exp_c[i][31:0]);
      rd(CTR_HI_BASE + 8'(8 * i), q);
      chk(q, {16'h0, exp_c[i][47:32]});
    end
  endtask

  //////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ev = '0;
    seed = 32'h5652;
    mismatches = 0;
    n_compared = 0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    // first rounds: every qualifier set, then a lone low bit
    for (int r = 0; r < 19; r++) begin
      c[0] = CODES[r];
      c[1] = CODES[(r + 7) % 19];
      c[2] = CODES[(r + 3) % 19];
      c[3] = CODES[(r + 11) % 19];
      for (int i = 0; i < 4; i++) begin
        m[i] = (r == 0) ? 8'hFF : (r == 1) ? 8'h01 : 8'(rnd() >> 24);
      end
      run_round();
    end
    // counter one loaded to all ones wraps on a single count
    wr(8'h04, 32'h0040_8010);
    wr(8'h1C, 32'h0000_FFFF);
    wr(8'h18, 32'hFFFF_FFFF);
    v1 = '0;
    v1.ingress_not_empty = 7'h01;
    @(posedge ref_clk);
    ev <= v1;
    @(posedge ref_clk);
    ev <= '0;
    repeat (3) @(posedge ref_clk);
    chk({28'h0, ctr_wrapped}, 32'h2);
    rd(8'h18, q);
    chk(q, 32'h0);
    rd(8'h1C, q);
    chk(q, 32'h0);
    rd(STATUS_OFS, q);
    chk({28'h0, q[3:0]}, 32'h2);
    wr(STATUS_OFS, 32'h2);
    @(negedge ref_clk);
    chk({28'h0, ctr_wrapped}, 32'h0);
    // unmapped places read zero and ignore writes
    rd(8'h40, q);
    chk(q, 32'h0);
    wr(8'h44, 32'hFFFF_FFFF);
    rd(8'h04, q);
    chk(q, 32'h0040_8010);
    // threshold two on counter zero, edge detect on counter two
    wr(8'h00, 32'h0242_8011);
    wr(8'h08, 32'h0046_8010);
    for (int k = 0; k < 4; k++) begin
      v1 = '0;
      v1.ingress_entry_writes = 7'((16'h0713 >> (4 * k)) & 16'h000F);
      v1.ingress_not_empty = 7'((4'hD >> k) & 4'h1);
      @(posedge ref_clk);
      ev <= v1;
    end
    @(posedge ref_clk);
    ev <= '0;
    repeat (3) @(posedge ref_clk);
    rd(CTR_LO_BASE, q);
    chk(q, 32'h2);
    rd(CTR_LO_BASE + 8'h10, q);
    chk(q, 32'h2);
    // reset in mid-run returns the control words to zero
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h04, q);
    chk(q, 32'h0);
    rd(CTR_LO_BASE, q);
    chk(q, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
